//--- otm_frame_pos.sv
`timescale 1ns/1ns
// byte position tracker: one byte position per clock after the frame strobe
module otm_frame_pos (
  input logic ref_clk,
  input logic reset,
  input logic frameStart,
  input logic mfStart,
  input logic [6:0] nSlots,
  input logic [11:0] payLast,
  output otm_pkg::otm_pos_s pos
);
  import otm_pkg::*;

  otm_pos_s pos_r; // position of the byte in this cycle

  // row and column walk, frame ends after the last byte of row 4
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pos_r.valid <= 1'b0;
      pos_r.row <= 2'h0;
      pos_r.col <= COL_FIRST;
    end else if (frameStart) begin
      pos_r.valid <= 1'b1;
      pos_r.row <= 2'h0;
      pos_r.col <= COL_FIRST;
    end else if (pos_r.valid && pos_r.col == COL_LAST) begin
      pos_r.col <= COL_FIRST;
      pos_r.row <= 2'(pos_r.row + 2'h1);
      // no byte beyond row 4 until the next strobe
      if (pos_r.row == ROW_LAST) begin
        pos_r.valid <= 1'b0;
      end
    end else if (pos_r.valid) begin
      pos_r.col <= 12'(pos_r.col + 12'h001);
    end
  end

  // payload slot interleave runs on across rows and frames [R6] [R25]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pos_r.slot <= 7'h00;
    end else if (frameStart && mfStart) begin
      pos_r.slot <= 7'h00;
    end else if (pos_r.valid && pos_r.col >= COL_PAY_FIRST && pos_r.col <= payLast) begin
      pos_r.slot <= (pos_r.slot >= 7'(nSlots - 7'h01)) ? 7'h00 : 7'(pos_r.slot + 7'h01);
    end
  end

  // multiframe count picks the slot owning this frame's overhead [R8] [R25]
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pos_r.mf <= 7'h00;
    end else if (frameStart) begin
      if (mfStart || pos_r.mf >= 7'(nSlots - 7'h01)) begin
        pos_r.mf <= 7'h00;
      end else begin
        pos_r.mf <= 7'(pos_r.mf + 7'h01);
      end
    end
  end

  assign pos = pos_r;
endmodule : otm_frame_pos

//--- otm_pkg.sv
package otm_pkg;
  // frame geometry, columns counted from 1, rows from 0
  localparam logic [11:0] COL_FIRST = 12'h001;
  localparam logic [11:0] COL_OH_A = 12'h00f; // column 15
  localparam logic [11:0] COL_OH_B = 12'h010; // column 16
  localparam logic [11:0] COL_PAY_FIRST = 12'h011; // column 17
  localparam logic [11:0] COL_LAST = 12'hef0; // column 3824
  localparam logic [11:0] COL_PAY_LAST_K4 = 12'hee8; // 3816, then fixed stuff
  localparam logic [1:0] ROW_LAST = 2'h3;
  localparam logic [1:0] GMP_OH_ROWS = 2'h3;
  localparam logic [2:0] GMP_IDX_COL15 = 3'h3; // column 15 carries bytes 3..5
  localparam logic [2:0] AMP_OH_BYTES = 3'h4;
  localparam logic [2:0] GMP_OH_BYTES = 3'h6;
  localparam int unsigned NUM_SLOTS = 32'h50; // widest multiplex, 80 slots
  localparam logic [6:0] MAX_OWNERS = 7'h50;
  // 1.25G slots per higher-order container
  localparam logic [6:0] TS_OPU1 = 7'h02;
  localparam logic [6:0] TS_OPU2 = 7'h08;
  localparam logic [6:0] TS_OPU3 = 7'h20;
  localparam logic [6:0] TS_OPU4 = 7'h50;
  localparam logic [6:0] TS_OPU25 = 7'h14;
  localparam logic [6:0] TS_OPU50 = 7'h28;
  // AMP payload geometry (1.25G form), bytes per slot per multiframe
  localparam int unsigned SLOT_BYTES = 32'h3b80; // 15232
  localparam int unsigned AMP01_COLS = 32'h770; // 1904
  localparam int unsigned AMP01_ROWS = 32'h8;
  localparam int unsigned AMP12_COLS = 32'h3b8; // 952
  localparam int unsigned AMP12_ROWS = 32'h20;
  localparam int unsigned AMP13_COLS = 32'hee; // 238
  localparam int unsigned AMP13_ROWS = 32'h80;
  localparam int unsigned AMP23_COLS = 32'h3b8;
  localparam int unsigned AMP23_ROWS = 32'h80;
  localparam logic [6:0] AMP01_TS = 7'(AMP01_COLS * AMP01_ROWS / SLOT_BYTES);
  localparam logic [6:0] AMP12_TS = 7'(AMP12_COLS * AMP12_ROWS / SLOT_BYTES);
  localparam logic [6:0] AMP13_TS = 7'(AMP13_COLS * AMP13_ROWS / SLOT_BYTES);
  localparam logic [6:0] AMP23_TS = 7'(AMP23_COLS * AMP23_ROWS / SLOT_BYTES);

  typedef enum logic [2:0] {OPU1, OPU2, OPU3, OPU4, OPU25, OPU50} otm_opu_e;
  typedef enum logic [2:0] {CT_NONE, CT_AMP01, CT_AMP12, CT_AMP13, CT_AMP23,
    CT_GMP} otm_ctype_e;
  typedef enum logic [2:0] {BK_PASS, BK_PAY, BK_OH, BK_RSV, BK_MFI} otm_kind_e;

  typedef struct packed {
    otm_ctype_e ctype;
    logic [6:0] owner;
  } otm_ent_s;
  typedef struct packed {
    logic valid;
    logic [1:0] row;
    logic [11:0] col;
    logic [6:0] slot;
    logic [6:0] mf;
  } otm_pos_s;
  typedef struct packed {
    logic pay;
    logic oh;
    logic [6:0] owner;
    logic [2:0] idx;
  } otm_req_s;
  typedef struct packed {
    logic sof;
    otm_kind_e kind;
    logic [7:0] data;
  } otm_out_s;

  function automatic logic [6:0] slotsOf(input otm_opu_e o);
    case (o)
      OPU1: slotsOf = TS_OPU1;
      OPU2: slotsOf = TS_OPU2;
      OPU3: slotsOf = TS_OPU3;
      OPU4: slotsOf = TS_OPU4;
      OPU25: slotsOf = TS_OPU25;
      OPU50: slotsOf = TS_OPU50;
      default: slotsOf = TS_OPU1;
    endcase
  endfunction : slotsOf

  function automatic logic [6:0] ampTs(input otm_ctype_e t);
    case (t)
      CT_AMP01: ampTs = AMP01_TS;
      CT_AMP12: ampTs = AMP12_TS;
      CT_AMP13: ampTs = AMP13_TS;
      CT_AMP23: ampTs = AMP23_TS;
      default: ampTs = 7'h00;
    endcase
  endfunction : ampTs

  function automatic logic isAmp(input otm_ctype_e t);
    isAmp = (t == CT_AMP01) || (t == CT_AMP12) || (t == CT_AMP13) || (t == CT_AMP23);
  endfunction : isAmp
endpackage : otm_pkg

//--- otm_slot_table.sv
`timescale 1ns/1ns
// static slot allocation table, one entry per 1.25G slot
module otm_slot_table (
  input logic ref_clk,
  input logic reset,
  input logic clear,
  input logic wr,
  input logic wrPair,
  input logic [6:0] wrSlot,
  input logic [6:0] wrSlot2,
  input otm_pkg::otm_ent_s wrEnt,
  input logic [6:0] rdSlotA,
  output otm_pkg::otm_ent_s entA,
  input logic [6:0] rdSlotB,
  output otm_pkg::otm_ent_s entB,
  output logic lastB,
  output logic busy1,
  output logic busy2,
  output logic [6:0] ownCnt
);
  import otm_pkg::*;

  otm_ent_s ent_r [NUM_SLOTS]; // type and owner per slot
  logic [6:0] maxSlot_r [NUM_SLOTS]; // highest slot held, per owner
  logic [6:0] cnt_r [NUM_SLOTS]; // slots held, per owner
  logic [6:0] topSlot; // highest slot of this write

  assign topSlot = wrPair ? wrSlot2 : wrSlot;

  // table storage; entries are only added, clear wipes everything
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        ent_r[i] <= '0;
        maxSlot_r[i] <= 7'h00;
        cnt_r[i] <= 7'h00;
      end
    end else if (clear) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        ent_r[i] <= '0;
        maxSlot_r[i] <= 7'h00;
        cnt_r[i] <= 7'h00;
      end
    end else if (wr) begin
      ent_r[wrSlot] <= wrEnt;
      // paired slot makes a 2.5G slot out of two 1.25G slots [R9]
      if (wrPair) begin
        ent_r[wrSlot2] <= wrEnt;
      end
      cnt_r[wrEnt.owner] <= 7'(cnt_r[wrEnt.owner] + (wrPair ? 7'h02 : 7'h01));
      if (topSlot > maxSlot_r[wrEnt.owner]) begin
        maxSlot_r[wrEnt.owner] <= topSlot;
      end
    end
  end

  // read ports, out-of-range indices read as empty on entA/entB and as held on busy1/busy2
  assign entA = (rdSlotA < MAX_OWNERS) ? ent_r[rdSlotA] : '0;
  assign entB = (rdSlotB < MAX_OWNERS) ? ent_r[rdSlotB] : '0;
  assign busy1 = (wrSlot < MAX_OWNERS) ? (ent_r[wrSlot].ctype != CT_NONE) : 1'b1;
  assign busy2 = (wrSlot2 < MAX_OWNERS) ? (ent_r[wrSlot2].ctype != CT_NONE) : 1'b1;
  assign ownCnt = (wrEnt.owner < MAX_OWNERS) ? cnt_r[wrEnt.owner] : 7'h7f;
  // the owner's highest slot carries the single GMP overhead [R7]
  assign lastB = (entB.ctype == CT_GMP) && (entB.owner < MAX_OWNERS) &&
    (maxSlot_r[entB.owner] == rdSlotB);
endmodule : otm_slot_table

//--- otm_tsmux.sv
`timescale 1ns/1ns
// Overview of operation
// R1 - AMP only for 0in1, 1in2, 1in3, 2in3
// R2 - GMP in OPU2/3/4/25/50 with bounded ts
// R3 - AMP overhead four bytes per slot
// R4 - AMP geometry sets slots per container
// R5 - GMP overhead is one six-byte instance
// R6 - GMP payload spreads over ts slots
// R7 - GMP overhead in highest allocated slot
// R8 - AMP overhead follows each slot's frame
// R9 - 2.5G slot equals 1.25G pair a,a+N/2
// R10 - ODTU01 takes one of two slots
// R11 - ODTU12 one 2.5G or two 1.25G slots
// R12 - ODTU13 one 2.5G or two 1.25G slots
// R13 - ODTU23 four 2.5G or eight 1.25G slots
// R14 - GMP slots free, bounded by slot count
// R15 - GMP only in 1.25G slots
// R16 - multiframe identifier emitted for k>=4
// R17 - AMP payload one-for-one, overhead column 16
// R18 - AMP column 15 overhead reserved
// R19 - GMP overhead columns 15/16, rows 1-3
// R20 - GMP payload one-for-one into slots
// R21 - OPU50 multiframe uses six low bits
// R22 - AMP JC rows 1-3, NJO row 4
// R23 - GMP count then phase bytes
// R24 - one slot never shared by two owners
// R25 - positions derived from frame strobe
module otm_tsmux (
  input logic ref_clk,
  input logic reset,
  input otm_pkg::otm_opu_e opuSel, // higher-order container size
  input logic halfRate, // configure in 2.5G slots
  input logic frameStart, // cycle before row 1 column 1
  input logic mfStart, // with frameStart: multiframe restarts
  input logic cfgWr,
  input logic [6:0] cfgSlot, // zero-based slot number
  input otm_pkg::otm_ent_s cfgEnt,
  input logic cfgClear,
  output logic cfgAck,
  output logic cfgErr,
  output otm_pkg::otm_req_s req, // byte request to justification logic
  input logic [7:0] payByte, // answer one cycle after req.pay
  input logic [7:0] ohByte, // answer one cycle after req.oh
  output otm_pkg::otm_out_s outByte // to frame assembler
);
  import otm_pkg::*;

  logic [6:0] nSlots; // slots of the selected container
  logic [11:0] payLast; // last payload column
  logic [6:0] halfSlots; // 2.5G slot count
  otm_pos_s pos; // position of the current byte
  otm_ent_s entA; // owner of the payload slot
  otm_ent_s entB; // owner of this frame's overhead slot
  logic lastB; // overhead slot is the GMP owner's last
  logic busy1, busy2; // targeted slots already held
  logic [6:0] ownCnt; // slots the owner already holds
  logic [6:0] pairSlot; // partner for a 2.5G write
  logic [6:0] addCnt; // slots this write adds
  logic [6:0] cntLimit; // slots the container may hold
  logic fits, inRange, cntOk, cfgOk, wrEn;
  otm_kind_e kind; // what the current byte is
  logic [7:0] mfiByte; // multiframe identifier value
  otm_kind_e kindD1_r; // byte kind, one stage on
  logic sofD1_r; // first byte of frame, one stage on
  logic [7:0] mfiD1_r; // identifier, one stage on
  otm_out_s out_r; // registered output byte
  logic cfgAck_r, cfgErr_r;

  assign nSlots = slotsOf(opuSel);
  assign halfSlots = nSlots >> 1;
  // OPU4 ends payload early, the rest is fixed stuff
  assign payLast = (opuSel == OPU4) ? COL_PAY_LAST_K4 : COL_LAST;

  // byte position from the frame strobe [R25]
  otm_frame_pos uPos (
    .ref_clk(ref_clk),
    .reset(reset),
    .frameStart(frameStart),
    .mfStart(mfStart),
    .nSlots(nSlots),
    .payLast(payLast),
    .pos(pos)
  );

  otm_slot_table uTable (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(cfgClear),
    .wr(wrEn),
    .wrPair(halfRate),
    .wrSlot(cfgSlot),
    .wrSlot2(pairSlot),
    .wrEnt(cfgEnt),
    .rdSlotA(pos.slot),
    .entA(entA),
    .rdSlotB(pos.mf),
    .entB(entB),
    .lastB(lastB),
    .busy1(busy1),
    .busy2(busy2),
    .ownCnt(ownCnt)
  );

  // admission check on each table write
  always_comb begin
    // 2.5G slot i is the 1.25G pair i and i+N/2 [R9]
    pairSlot = 7'(cfgSlot + halfSlots);
    // container pairs per higher-order size [R1] [R2]
    case (cfgEnt.ctype)
      CT_AMP01: fits = (opuSel == OPU1);
      CT_AMP12: fits = (opuSel == OPU2);
      CT_AMP13: fits = (opuSel == OPU3);
      CT_AMP23: fits = (opuSel == OPU3);
      CT_GMP: fits = (opuSel != OPU1) && !halfRate; // [R15]
      default: fits = 1'b0;
    endcase
    // 2.5G slots exist only in OPU2 and OPU3
    if (halfRate && opuSel != OPU2 && opuSel != OPU3) begin
      fits = 1'b0;
    end
    // slot indices bounded by the container's slot count [R11] [R12] [R13] [R14]
    inRange = halfRate ? (cfgSlot < halfSlots) : (cfgSlot < nSlots);
    addCnt = halfRate ? 7'h02 : 7'h01;
    // AMP slot count from payload geometry [R4] [R10]
    cntLimit = (cfgEnt.ctype == CT_GMP) ? nSlots : ampTs(cfgEnt.ctype);
    cntOk = (7'(ownCnt + addCnt) <= cntLimit) && (cfgEnt.owner < MAX_OWNERS);
    // a held slot is never reassigned [R24]
    cfgOk = fits && inRange && cntOk && !busy1 && !(halfRate && busy2);
  end

  assign wrEn = cfgWr && cfgOk && !cfgClear;

  // write outcome, one-cycle pulses
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfgAck_r <= 1'b0;
      cfgErr_r <= 1'b0;
    end else begin
      cfgAck_r <= wrEn;
      cfgErr_r <= cfgWr && !cfgClear && !cfgOk;
    end
  end

  // identifier value; OPU50 counts in the low six bits [R16] [R21]
  assign mfiByte = (opuSel == OPU50) ? {2'b00, pos.mf[5:0]} : {1'b0, pos.mf};

  // classify the byte and ask upstream for it
  always_comb begin
    kind = BK_PASS;
    req = '0;
    if (!pos.valid) begin
      kind = BK_PASS;
    end else if (pos.col >= COL_PAY_FIRST) begin
      if (pos.col > payLast) begin
        kind = BK_RSV; // fixed stuff
      end else if (entA.ctype != CT_NONE) begin
        // payload byte copied one-for-one [R17] [R20]
        kind = BK_PAY;
        req.pay = 1'b1;
        req.owner = entA.owner;
      end else begin
        kind = BK_RSV; // unallocated slot
      end
    end else if (pos.col == COL_OH_A || pos.col == COL_OH_B) begin
      if (pos.row == ROW_LAST) begin
        if (pos.col == COL_OH_A) begin
          kind = BK_PASS; // payload structure byte, downstream's
        end else if (opuSel == OPU4 || opuSel == OPU25 || opuSel == OPU50) begin
          kind = BK_MFI; // [R16]
        end else if (isAmp(entB.ctype)) begin
          // negative justification byte in row 4 [R22] [R3]
          kind = BK_OH;
          req.oh = 1'b1;
          req.owner = entB.owner;
          req.idx = 3'(pos.row);
        end else begin
          kind = BK_RSV;
        end
      end else if (isAmp(entB.ctype)) begin
        // AMP overhead only in column 16, column 15 reserved [R8] [R17] [R18] [R22]
        if (pos.col == COL_OH_B) begin
          kind = BK_OH;
          req.oh = 1'b1;
          req.owner = entB.owner;
          req.idx = 3'(pos.row);
        end else begin
          kind = BK_RSV;
        end
      end else if (lastB && pos.row < GMP_OH_ROWS) begin
        // six GMP bytes: count in 16, phase in 15 [R5] [R7] [R19] [R23]
        kind = BK_OH;
        req.oh = 1'b1;
        req.owner = entB.owner;
        req.idx = (pos.col == COL_OH_B) ? 3'(pos.row) : 3'(GMP_IDX_COL15 + 3'(pos.row));
      end else begin
        kind = BK_RSV; // other slot overhead reserved [R19]
      end
    end
  end

  // stage 1: hold classification while upstream answers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      kindD1_r <= BK_PASS;
      sofD1_r <= 1'b0;
      mfiD1_r <= 8'h00;
    end else begin
      kindD1_r <= kind;
      sofD1_r <= pos.valid && pos.row == 2'h0 && pos.col == COL_FIRST;
      mfiD1_r <= mfiByte;
    end
  end

  // stage 2: select the byte; reserved and pass-through bytes are zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      out_r <= '0;
    end else begin
      out_r.sof <= sofD1_r;
      out_r.kind <= kindD1_r;
      case (kindD1_r)
        BK_PAY: out_r.data <= payByte;
        BK_OH: out_r.data <= ohByte;
        BK_MFI: out_r.data <= mfiD1_r;
        default: out_r.data <= 8'h00;
      endcase
    end
  end

  assign outByte = out_r;
  assign cfgAck = cfgAck_r;
  assign cfgErr = cfgErr_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_pay_owner: assert property (pos.valid && pos.col >= COL_PAY_FIRST && pos.col <= payLast
    && entA.ctype != CT_NONE |-> req.pay && req.owner == entA.owner) // [R17]
    else $error("payload byte not requested from slot owner");
  a_pay_latency: assert property (req.pay |-> ##2 outByte.kind == BK_PAY) // [R20]
    else $error("payload byte not delivered two cycles later");
  a_amp_col15: assert property (req.oh && isAmp(entB.ctype) |-> pos.col == COL_OH_B) // [R18]
    else $error("AMP overhead outside column 16");
  a_amp_idx: assert property (req.oh && isAmp(entB.ctype) |-> req.idx < AMP_OH_BYTES) // [R3]
    else $error("AMP overhead index out of range");
  a_gmp_last: assert property (req.oh && entB.ctype == CT_GMP
    |-> lastB && pos.row < GMP_OH_ROWS && req.idx < GMP_OH_BYTES) // [R7]
    else $error("GMP overhead outside last slot rows 1-3");
  // row 4 holds the structure byte and, for OPU4/25/50, the identifier byte, so only the three overhead rows are checked here
  a_gmp_rsv: assert property (pos.valid && entB.ctype == CT_GMP && !lastB && pos.row < GMP_OH_ROWS
    && (pos.col == COL_OH_A || pos.col == COL_OH_B) |-> ##2 outByte.data == 8'h00) // [R19]
    else $error("reserved GMP overhead byte not zero");
  a_no_share: assert property (cfgWr && !cfgClear && busy1 |-> ##1 cfgErr && !cfgAck) // [R24]
    else $error("write to held slot accepted");
  a_gmp_half: assert property (cfgWr && halfRate && cfgEnt.ctype == CT_GMP
    |-> ##1 cfgErr) // [R15]
    else $error("GMP accepted in 2.5G slots");
  a_sof_time: assert property (frameStart |-> ##3 outByte.sof) // [R25]
    else $error("frame start not seen three cycles later");
  a_mfi_k50: assert property (outByte.kind == BK_MFI && opuSel == OPU50
    |-> outByte.data[7:6] == 2'b00) // [R21]
    else $error("OPU50 identifier beyond six bits");

  c_gmp_oh: cover property (req.oh && entB.ctype == CT_GMP ##1 req.oh);
  c_amp_njo: cover property (req.oh && isAmp(entB.ctype) && pos.row == ROW_LAST);
  c_pair_wr: cover property (cfgWr && halfRate ##1 cfgAck);
  c_mfi: cover property (outByte.kind == BK_MFI);
endmodule : otm_tsmux

//--- otm_tsmux_tb.sv
`timescale 1ns/1ns
// self-checking bench: slot configuration and whole-frame byte placement
module otm_tsmux_tb;
  import otm_pkg::*;
  logic ref_clk;
  logic reset;
  otm_opu_e opuSel;
  logic halfRate;
  logic frameStart;
  logic mfStart;
  logic cfgWr;
  logic [6:0] cfgSlot;
  otm_ent_s cfgEnt;
  logic cfgClear;
  logic cfgAck;
  logic cfgErr;
  otm_req_s req;
  logic [7:0] payByte;
  logic [7:0] ohByte;
  otm_out_s outByte;
  int n_errors = 0;
  int n_tests = 0;
  int nS; // slots of the selected container
  bit mfiOn; // multiframe byte present
  int pc; // running payload column count, slot interleave
  logic [3:0] seqE; // expected payload sequence stamp
  otm_ctype_e tTyp [0:79]; // expected allocation table
  logic [6:0] tOwn [0:79];
  // scattered eight-slot container, gaps left on purpose
  logic [6:0] amp23Sl [8] = '{7'h03, 7'h05, 7'h07, 7'h09, 7'h0b, 7'h0d, 7'h14, 7'h1f};

  otm_tsmux dut_u (.ref_clk(ref_clk), .reset(reset), .opuSel(opuSel), .halfRate(halfRate),
    .frameStart(frameStart), .mfStart(mfStart), .cfgWr(cfgWr), .cfgSlot(cfgSlot),
    .cfgEnt(cfgEnt), .cfgClear(cfgClear), .cfgAck(cfgAck), .cfgErr(cfgErr), .req(req),
    .payByte(payByte), .ohByte(ohByte), .outByte(outByte));
  otm_upstream_model up_u (.ref_clk(ref_clk), .reset(reset), .req(req),
    .payByte(payByte), .ohByte(ohByte));

  // free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // reset for six cycles and pick the container size while held
  task automatic apply_reset(input otm_opu_e o);
    @(posedge ref_clk);
    reset <= 1'b1;
    opuSel <= o;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk("rstOut", {2'b0, cfgAck, cfgErr, outByte}, 16'h0000);
    chk("rstReq", {4'h0, req}, 16'h0000);
    for (int i = 0; i < 80; i++) tTyp[i] = CT_NONE;
    seqE = 4'h0;
    case (o)
      OPU1: nS = int'(TS_OPU1);
      OPU2: nS = int'(TS_OPU2);
      OPU3: nS = int'(TS_OPU3);
      default: nS = int'(TS_OPU25);
    endcase
    mfiOn = (o == OPU4) || (o == OPU25) || (o == OPU50);
  endtask : apply_reset

  // one configuration write, answer judged 1 ns after the clock edge that takes it
  task automatic wr(input otm_ctype_e ct, input logic [6:0] ow, input logic [6:0] sl,
      input logic hf, input logic er);
    @(posedge ref_clk);
    cfgWr <= 1'b1;
    cfgEnt <= '{ctype: ct, owner: ow};
    cfgSlot <= sl;
    halfRate <= hf;
    @(posedge ref_clk);
    cfgWr <= 1'b0;
    #1;
    chk("cfgResp", {14'h0, cfgAck, cfgErr}, {14'h0, !er, er});
    if (!er) begin
      tTyp[sl] = ct;
      tOwn[sl] = ow;
      if (hf) begin
        tTyp[int'(sl) + nS / 2] = ct;
        tOwn[int'(sl) + nS / 2] = ow;
      end
    end
  endtask : wr

  task automatic clear_table();
    @(posedge ref_clk);
    cfgClear <= 1'b1;
    @(posedge ref_clk);
    cfgClear <= 1'b0;
    for (int i = 0; i < 80; i++) tTyp[i] = CT_NONE;
  endtask : clear_table

  // highest slot held by an owner, -1 if none
  function automatic int lastOf(input logic [6:0] o);
    int h;
    h = -1;
    for (int i = 0; i < 80; i++) if (tTyp[i] != CT_NONE && tOwn[i] === o) h = i;
    return h;
  endfunction : lastOf

  // strobe a frame and compare every output byte against the table
  task automatic run_frame(input logic mfs, input int mfv);
    int r;
    int c;
    int s;
    logic [6:0] o;
    otm_out_s e;
    @(posedge ref_clk);
    frameStart <= 1'b1;
    mfStart <= mfs;
    if (mfs) pc = 0;
    @(posedge ref_clk);
    frameStart <= 1'b0;
    mfStart <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int n = 0; n < 15296; n++) begin
      r = n / 3824;
      c = n % 3824 + 1;
      e = '{sof: (n == 0), kind: BK_PASS, data: 8'h00};
      if (c == 15 || c == 16) begin
        s = mfv % nS;
        o = tOwn[s];
        if (c == 16 && r == 3 && mfiOn) begin
          e.kind = BK_MFI;
          e.data = 8'(mfv);
        end else if (c == 16 && tTyp[s] != CT_NONE && tTyp[s] != CT_GMP) begin
          e.kind = BK_OH;
          e.data = {o[4:0], 3'(r)};
        end else if (r < 3 && tTyp[s] == CT_GMP && lastOf(o) == s) begin
          e.kind = BK_OH;
          e.data = {o[4:0], (c == 16) ? 3'(r) : 3'(r + 3)};
        end else if (!(c == 15 && r == 3)) begin
          e.kind = BK_RSV;
        end
      end else if (c >= 17) begin
        s = pc % nS;
        pc++;
        o = tOwn[s];
        if (tTyp[s] == CT_NONE) begin
          e.kind = BK_RSV;
        end else begin
          e.kind = BK_PAY;
          e.data = {o[3:0], seqE};
          seqE++;
        end
      end
      #1;
      chk("outByte", {4'h0, outByte}, {4'h0, e});
      @(posedge ref_clk);
    end
  endtask : run_frame

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    opuSel = OPU1;
    halfRate = 1'b0;
    frameStart = 1'b0;
    mfStart = 1'b0;
    cfgWr = 1'b0;
    cfgSlot = 7'h00;
    cfgEnt = '{ctype: CT_NONE, owner: 7'h00};
    cfgClear = 1'b0;
    // single-slot container: one of two slots, then wiped and reused
    apply_reset(OPU1);
    wr(CT_AMP01, 7'h01, 7'h00, 1'b0, 1'b0);
    wr(CT_AMP01, 7'h02, 7'h02, 1'b0, 1'b1);
    wr(CT_AMP01, 7'h01, 7'h01, 1'b0, 1'b1);
    wr(CT_GMP, 7'h02, 7'h01, 1'b0, 1'b1);
    clear_table();
    wr(CT_AMP01, 7'h01, 7'h00, 1'b0, 1'b0);
    // two-slot containers in the 8-slot size
    apply_reset(OPU2);
    wr(CT_AMP12, 7'h01, 7'h03, 1'b1, 1'b0);
    wr(CT_AMP12, 7'h02, 7'h07, 1'b0, 1'b1);
    wr(CT_AMP12, 7'h02, 7'h04, 1'b1, 1'b1);
    wr(CT_AMP12, 7'h02, 7'h00, 1'b0, 1'b0);
    wr(CT_AMP12, 7'h02, 7'h05, 1'b0, 1'b0);
    wr(CT_GMP, 7'h03, 7'h08, 1'b0, 1'b1);
    wr(CT_GMP, 7'h03, 7'h01, 1'b0, 1'b0);
    // 32-slot size: paired, scattered eight-slot and refused writes, then a frame
    apply_reset(OPU3);
    wr(CT_AMP13, 7'h01, 7'h00, 1'b1, 1'b0);
    wr(CT_AMP13, 7'h03, 7'h02, 1'b0, 1'b0);
    wr(CT_AMP13, 7'h03, 7'h12, 1'b0, 1'b0);
    foreach (amp23Sl[i]) begin
      wr(CT_AMP23, 7'h02, amp23Sl[i], 1'b0, 1'b0);
    end
    wr(CT_AMP23, 7'h02, 7'h1e, 1'b0, 1'b1);
    wr(CT_AMP01, 7'h04, 7'h01, 1'b0, 1'b1);
    wr(CT_GMP, 7'h04, 7'h01, 1'b1, 1'b1);
    wr(CT_AMP13, 7'h04, 7'h20, 1'b0, 1'b1);
    wr(CT_AMP13, 7'h04, 7'h10, 1'b1, 1'b1);
    wr(CT_AMP13, 7'h04, 7'h10, 1'b0, 1'b1);
    wr(CT_AMP13, 7'h03, 7'h04, 1'b0, 1'b1);
    wr(CT_NONE, 7'h04, 7'h01, 1'b0, 1'b1);
    run_frame(1'b1, 0);
    // 20-slot size: two-slot GMP container over two frames of the multiframe
    apply_reset(OPU25);
    wr(CT_GMP, 7'h05, 7'h00, 1'b0, 1'b0);
    wr(CT_GMP, 7'h05, 7'h01, 1'b0, 1'b0);
    wr(CT_GMP, 7'h06, 7'h14, 1'b0, 1'b1);
    wr(CT_GMP, 7'h50, 7'h02, 1'b0, 1'b1);
    wr(CT_AMP13, 7'h06, 7'h02, 1'b0, 1'b1);
    wr(CT_GMP, 7'h06, 7'h02, 1'b1, 1'b1);
    run_frame(1'b1, 0);
    run_frame(1'b0, 1);
    conclude();
  end
endmodule : otm_tsmux_tb

//--- otm_upstream_model.sv
`timescale 1ns/1ns
// upstream justification stand-in: answers each byte request one cycle later
module otm_upstream_model (
  input logic ref_clk,
  input logic reset,
  input otm_pkg::otm_req_s req,
  output logic [7:0] payByte,
  output logic [7:0] ohByte
);
  import otm_pkg::*;
  logic [3:0] seq_r; // payload request count, stamps each byte
  // payload answer: owner plus sequence, so a byte landing one cycle off shows up
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seq_r <= 4'h0;
      payByte <= 8'h00;
    end else if (req.pay) begin
      seq_r <= seq_r + 4'h1;
      payByte <= {req.owner[3:0], seq_r};
    end else begin
      // nothing asked: toggle so a stale byte never passes for data
      payByte <= ~payByte;
    end
  end
  // overhead answer: owner and byte index within the container overhead
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ohByte <= 8'h00;
    end else if (req.oh) begin
      ohByte <= {req.owner[4:0], req.idx};
    end else begin
      ohByte <= ~ohByte;
    end
  end
endmodule : otm_upstream_model
